/* rtl/echo_canceller_host_port.sv */
// Non-multiplexed host port with device reset, init walk and interrupt line
// How it works
// - An access happens only while data strobe and chip select are low.
// - read_not_write picks direction: device drives on reads, samples writes.
// - Eight-bit data path; bus released whenever no read data is driven.
// - Acknowledge pulled low once the transfer is done, released otherwise.
// - Interrupt line pulled low when any channel raises an event outside standby and the init walk.
// - Interrupt line released once every queued event is read, or on the next clock edge after device reset goes low.
// - Device reset low holds the device in reset and low-power standby.
// - After reset release, init walk sets all control registers to defaults.
// - Each access carries an eleven-bit register address.
`timescale 1ns/1ns
`default_nettype none
module echo_canceller_host_port (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic device_reset_n,
  input wire logic chip_select_n,
  input wire logic data_strobe_n,
  input wire logic read_not_write,
  input wire logic [echo_port_pkg::ADDR_W-1:0] register_address,
  input wire logic [echo_port_pkg::DATA_W-1:0] host_data_in,
  input wire logic channel_event,
  input wire logic [echo_port_pkg::CHAN_W-1:0] channel_event_id,
  output logic [echo_port_pkg::DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  output logic transfer_ack_out,
  output logic transfer_ack_oe,
  output logic host_interrupt_out,
  output logic host_interrupt_oe,
  output logic standby
);
  function automatic logic access_on(input logic cs_n, input logic ds_n);
    return !cs_n && !ds_n;
  endfunction : access_on

  echo_port_pkg::port_state_t state_reg, state_next;
  logic [echo_port_pkg::CTRL_IDX_W-1:0] init_idx_reg, init_idx_next;
  logic [echo_port_pkg::DATA_W-1:0] data_reg, data_next;
  logic data_oe_reg, data_oe_next;
  logic ack_oe_reg, ack_oe_next;
  logic irq_oe_reg, irq_oe_next;
  logic standby_reg, standby_next;
  logic [echo_port_pkg::DATA_W-1:0] ctrl_mem [echo_port_pkg::CTRL_DEPTH];
  logic access, take, ctrl_hit, ctrl_wr, fifo_pop, fifo_flush, fifo_push;
  logic [echo_port_pkg::DATA_W-1:0] fifo_head, status_word, read_word;
  logic [echo_port_pkg::DATA_W-1:0] event_word;
  logic [echo_port_pkg::CTRL_IDX_W-1:0] ctrl_idx;
  logic fifo_empty;
  logic [echo_port_pkg::FIFO_CNT_W-1:0] fifo_count;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  assign access = access_on(chip_select_n, data_strobe_n);
  assign take = access && (state_reg == echo_port_pkg::ST_IDLE);
  assign ctrl_hit = (register_address < echo_port_pkg::CTRL_LIMIT);
  assign ctrl_idx = register_address[echo_port_pkg::CTRL_IDX_W-1:0];
  assign ctrl_wr = take && !read_not_write && ctrl_hit;
  assign fifo_pop = take && read_not_write
    && (register_address == echo_port_pkg::INT_FIFO_ADDR);
  assign fifo_flush = (state_reg == echo_port_pkg::ST_STANDBY)
    || (state_reg == echo_port_pkg::ST_INIT);
  assign fifo_push = channel_event && device_reset_n;
  assign event_word = {1'b1, 2'b00, channel_event_id};

  always_comb begin
    status_word = '0;
    status_word[echo_port_pkg::STAT_INIT_DONE] = 1'b1;
    status_word[echo_port_pkg::STAT_PENDING] = !fifo_empty;
    status_word[echo_port_pkg::STAT_COUNT_LSB +: echo_port_pkg::FIFO_CNT_W] =
      fifo_count;
    if (ctrl_hit) begin
      read_word = ctrl_mem[ctrl_idx];
    end else if (register_address == echo_port_pkg::STATUS_ADDR) begin
      read_word = status_word;
    end else if (register_address == echo_port_pkg::INT_FIFO_ADDR) begin
      read_word = fifo_empty ? echo_port_pkg::IDLE_DATA : fifo_head;
    end else begin
      read_word = echo_port_pkg::IDLE_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port sequencer
  always_comb begin
    state_next = state_reg;
    init_idx_next = init_idx_reg;
    data_next = data_reg;
    data_oe_next = data_oe_reg;
    ack_oe_next = ack_oe_reg;
    standby_next = !device_reset_n;
    // Queue is flushed in standby and init: line stays released there
    irq_oe_next = !fifo_empty && !fifo_flush;
    if (!device_reset_n) begin
      state_next = echo_port_pkg::ST_STANDBY;
      init_idx_next = '0;
      data_oe_next = 1'b0;
      ack_oe_next = 1'b0;
      irq_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        echo_port_pkg::ST_STANDBY: begin
          state_next = echo_port_pkg::ST_INIT;
        end
        echo_port_pkg::ST_INIT: begin
          init_idx_next = init_idx_reg + 1'b1;
          if (init_idx_reg == echo_port_pkg::CTRL_LAST) begin
            state_next = echo_port_pkg::ST_IDLE;
          end
        end
        echo_port_pkg::ST_IDLE: begin
          if (take) begin
            state_next = echo_port_pkg::ST_ACK;
            ack_oe_next = 1'b1;
            data_oe_next = read_not_write;
            data_next = read_not_write ? read_word : echo_port_pkg::IDLE_DATA;
          end
        end
        echo_port_pkg::ST_ACK: begin
          if (!access) begin
            state_next = echo_port_pkg::ST_IDLE;
            ack_oe_next = 1'b0;
            data_oe_next = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= echo_port_pkg::ST_STANDBY;
      init_idx_reg <= '0;
      data_reg <= echo_port_pkg::IDLE_DATA;
      data_oe_reg <= 1'b0;
      ack_oe_reg <= 1'b0;
      irq_oe_reg <= 1'b0;
      standby_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      init_idx_reg <= init_idx_next;
      data_reg <= data_next;
      data_oe_reg <= data_oe_next;
      ack_oe_reg <= ack_oe_next;
      irq_oe_reg <= irq_oe_next;
      standby_reg <= standby_next;
    end
  end

  // Control store: defaults loaded by the init walk, host writes otherwise
  always_ff @(posedge ref_clk) begin
    if (state_reg == echo_port_pkg::ST_INIT) begin
      ctrl_mem[init_idx_reg] <= echo_port_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_mem[ctrl_idx] <= host_data_in;
    end
  end

  // Open-drain pins only ever pull low
  logic od_low_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      od_low_reg <= 1'b0;
    end else begin
      od_low_reg <= 1'b0;
    end
  end

  irq_event_fifo event_queue (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .flush(fifo_flush),
    .push(fifo_push),
    .push_data(event_word),
    .pop(fifo_pop),
    .head(fifo_head),
    .empty(fifo_empty),
    .count(fifo_count)
  );

  assign host_data_out = data_reg;
  assign host_data_oe = data_oe_reg;
  assign transfer_ack_out = od_low_reg;
  assign transfer_ack_oe = ack_oe_reg;
  assign host_interrupt_out = od_low_reg;
  assign host_interrupt_oe = irq_oe_reg;
  assign standby = standby_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ack_cause_a: assert property ($rose(ack_oe_reg) |->
    $past(access) && $past(state_reg == echo_port_pkg::ST_IDLE))
    else $error("acknowledge without strobe and chip select");
  ack_release_a: assert property (
    ack_oe_reg && !access && device_reset_n |=> !ack_oe_reg && !data_oe_reg)
    else $error("acknowledge or bus held after strobe removed");
  read_drive_a: assert property ($rose(ack_oe_reg) |->
    data_oe_reg == $past(read_not_write))
    else $error("bus direction does not follow read_not_write");
  bus_release_a: assert property (data_oe_reg |-> ack_oe_reg)
    else $error("data bus driven outside an acknowledged read");
  standby_hold_a: assert property (!device_reset_n |=>
    standby_reg && !ack_oe_reg && !data_oe_reg && !irq_oe_reg)
    else $error("device not in standby while reset held");
  init_walk_a: assert property (
    $rose(state_reg == echo_port_pkg::ST_INIT) && device_reset_n
    |-> (state_reg == echo_port_pkg::ST_INIT)[*8])
    else $error("init walk cut short");
  irq_raise_a: assert property (
    fifo_push && state_reg inside {echo_port_pkg::ST_IDLE, echo_port_pkg::ST_ACK}
    && device_reset_n [*3] |-> ##[0:2] irq_oe_reg)
    else $error("interrupt not raised after channel event");
  irq_clear_a: assert property ($fell(irq_oe_reg) |->
    $past(fifo_pop, 2) || $past(fifo_flush, 2) || $past(!device_reset_n))
    else $error("interrupt released with events still queued");
  status_read_a: assert property (take && read_not_write
    && register_address == echo_port_pkg::STATUS_ADDR
    |=> data_oe_reg && host_data_out[echo_port_pkg::STAT_INIT_DONE])
    else $error("status read returned wrong data");

  write_seen_c: cover property (take && !read_not_write ##1 ack_oe_reg);
  fifo_read_c: cover property (fifo_pop ##[1:4] !irq_oe_reg);
  init_done_c: cover property (state_reg == echo_port_pkg::ST_INIT
    ##1 state_reg == echo_port_pkg::ST_IDLE);
endmodule : echo_canceller_host_port
`default_nettype wire

/* rtl/echo_port_pkg.sv */
// Constants and types shared by the echo canceller host port
package echo_port_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int CHAN_W = 5;
  localparam int CTRL_DEPTH = 64;
  localparam int CTRL_IDX_W = 6;
  localparam logic [CTRL_IDX_W-1:0] CTRL_LAST = 6'h3f;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL_LIMIT = 11'h040;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 11'h7fe;
  localparam logic [ADDR_W-1:0] INT_FIFO_ADDR = 11'h7ff;
  localparam int STAT_INIT_DONE = 0;
  localparam int STAT_PENDING = 1;
  localparam int STAT_COUNT_LSB = 2;
  localparam int EVT_VALID_BIT = 7;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_PTR_W = 4;
  localparam int FIFO_CNT_W = 5;
  localparam logic [DATA_W-1:0] IDLE_DATA = 8'h00;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_INIT = 2'b01,
    ST_IDLE = 2'b10,
    ST_ACK = 2'b11
  } port_state_t;
endpackage : echo_port_pkg

/* rtl/irq_event_fifo.sv */
// Interrupt event queue read out through the interrupt FIFO register
`timescale 1ns/1ns
`default_nettype none
module irq_event_fifo (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic push,
  input wire logic [echo_port_pkg::DATA_W-1:0] push_data,
  input wire logic pop,
  output logic [echo_port_pkg::DATA_W-1:0] head,
  output logic empty,
  output logic [echo_port_pkg::FIFO_CNT_W-1:0] count
);
  logic [echo_port_pkg::DATA_W-1:0] mem [echo_port_pkg::FIFO_DEPTH];
  logic [echo_port_pkg::FIFO_PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
  logic [echo_port_pkg::FIFO_PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
  logic [echo_port_pkg::FIFO_CNT_W-1:0] count_reg, count_next;
  logic do_push, do_pop, full;

  assign full = (count_reg == echo_port_pkg::FIFO_CNT_W'(echo_port_pkg::FIFO_DEPTH));
  assign empty = (count_reg == '0);
  assign count = count_reg;
  assign head = mem[rd_ptr_reg];
  // Events arriving while full are dropped
  assign do_push = push && !full && !flush;
  assign do_pop = pop && !empty && !flush;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (flush) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
    end else begin
      if (do_push) begin
        wr_ptr_next = wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_next = rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_next = count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end
endmodule : irq_event_fifo
`default_nettype wire

/* sim/host_model.sv */
// Host processor model driving the parallel register port
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic ref_clk,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic transfer_ack_oe,
  input wire logic transfer_ack_out,
  output logic chip_select_n,
  output logic data_strobe_n,
  output logic read_not_write,
  output logic [10:0] register_address,
  output logic [7:0] host_data_in
);
  logic [7:0] drv;
  logic [7:0] last;
  logic drv_en;
  logic ack_pin_n;
  // Acknowledge pin as the host sees it, pulled up while released
  assign ack_pin_n = transfer_ack_oe ? transfer_ack_out : 1'b1;
  initial begin
    chip_select_n = 1'b1;
    data_strobe_n = 1'b1;
    read_not_write = 1'b1;
    register_address = 11'h000;
    drv = 8'h00;
    drv_en = 1'b0;
    last = 8'h00;
  end
  // Released bus shows the inverse of its last level
  always_comb begin
    if (host_data_oe) host_data_in = host_data_out;
    else if (drv_en) host_data_in = drv;
    else host_data_in = ~last;
  end
  always @(posedge ref_clk) last <= host_data_in;
  task automatic access(input logic cs, input logic rnw,
      input logic [10:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk);
    chip_select_n <= ~cs;
    data_strobe_n <= 1'b0;
    read_not_write <= rnw;
    register_address <= a;
    drv <= d;
    drv_en <= ~rnw;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_pin_n !== 1'b0 && n < 200);
    ok = (ack_pin_n === 1'b0);
    q = host_data_in;
    data_strobe_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    if (ack_pin_n !== 1'b1 || host_data_oe !== 1'b0) ok = 1'b0;
    @(posedge ref_clk);
    chip_select_n <= 1'b1;
    drv_en <= 1'b0;
  endtask : access
endmodule : host_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the echo canceller host port
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk, nrst, device_reset_n, channel_event, ok;
  logic [4:0] channel_event_id;
  logic [4:0] ids [32];
  logic [7:0] host_data_out, host_data_in, q;
  logic [7:0] mem [64];
  logic host_data_oe, transfer_ack_out, transfer_ack_oe;
  logic host_interrupt_out, host_interrupt_oe, standby;
  logic chip_select_n, data_strobe_n, read_not_write;
  logic irq_pin_n;
  logic [10:0] register_address;
  int bad_count = 0;
  int checked = 0;
  int seed = 32'he7c4;
  int k;
  echo_canceller_host_port i_dut (.ref_clk, .nrst, .device_reset_n,
    .chip_select_n, .data_strobe_n, .read_not_write, .register_address,
    .host_data_in, .channel_event, .channel_event_id, .host_data_out,
    .host_data_oe, .transfer_ack_out, .transfer_ack_oe,
    .host_interrupt_out, .host_interrupt_oe, .standby);
  host_model i_host (.ref_clk, .host_data_out, .host_data_oe,
    .transfer_ack_oe, .transfer_ack_out, .chip_select_n, .data_strobe_n,
    .read_not_write, .register_address, .host_data_in);
  // Interrupt pin as the host sees it, pulled up while released
  assign irq_pin_n = host_interrupt_oe ? host_interrupt_out : 1'b1;
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] exp, got);
    checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check
  task automatic rd(input logic [10:0] a, input logic [7:0] exp);
    i_host.access(1'b1, 1'b1, a, 8'h00, q, ok);
    check("read ack", 8'h01, {7'h0, ok});
    check("read data", exp, q);
  endtask : rd
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    i_host.access(1'b1, 1'b0, a, d, q, ok);
    check("write ack", 8'h01, {7'h0, ok});
  endtask : wr
  function automatic logic [7:0] status_word(input logic [4:0] cnt);
    return {1'b0, cnt, cnt != 5'h00, 1'b1};
  endfunction : status_word
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      ids[i] = 5'($random(seed));
      channel_event <= 1'b1;
      channel_event_id <= ids[i];
    end
    @(posedge ref_clk);
    channel_event <= 1'b0;
  endtask : pulse
  task automatic drain(input int lo, input int hi);
    for (int i = lo; i < hi; i++) begin
      rd(echo_port_pkg::INT_FIFO_ADDR, {3'h4, ids[i]});
    end
  endtask : drain
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin : watchdog
    #3000000;
    bad_count++;
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    device_reset_n = 1'b1;
    channel_event = 1'b0;
    channel_event_id = 5'h00;
    repeat (3) @(posedge ref_clk);
    #1;
    check("standby", 8'h01, {7'h0, standby});
    @(posedge ref_clk);
    nrst <= 1'b1;
    rd(echo_port_pkg::STATUS_ADDR, 8'h01);
    for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    // Random writes, both ends of the control range first
    for (int i = 0; i < 24; i++) begin
      k = (i == 0) ? 0 : (i == 1) ? 63 : ($random(seed) & 63);
      mem[k] = 8'($random(seed));
      wr(11'(k), mem[k]);
    end
    wr(11'h400, 8'h5a);
    wr(echo_port_pkg::CTRL_LIMIT, 8'h3c);
    for (int i = 0; i < 64; i++) rd(11'(i), mem[i]);
    rd(11'h400, 8'h00);
    rd(echo_port_pkg::CTRL_LIMIT, 8'h00);
    i_host.access(1'b0, 1'b1, 11'h000, 8'h00, q, ok);
    check("unselected ack", 8'h00, {7'h0, ok});
    pulse(5);
    repeat (2) @(posedge ref_clk);
    #1;
    check("irq raised", 8'h00, {7'h0, irq_pin_n});
    rd(echo_port_pkg::STATUS_ADDR, status_word(5'd5));
    drain(0, 4);
    check("irq held", 8'h00, {7'h0, irq_pin_n});
    drain(4, 5);
    check("irq freed", 8'h01, {7'h0, irq_pin_n});
    rd(echo_port_pkg::INT_FIFO_ADDR, 8'h00);
    pulse(18);
    rd(echo_port_pkg::STATUS_ADDR, status_word(5'd16));
    drain(0, 16);
    pulse(1);
    wr(11'h005, 8'ha5);
    @(posedge ref_clk);
    device_reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("standby", 8'h01, {7'h0, standby});
    check("irq in reset", 8'h01, {7'h0, irq_pin_n});
    @(posedge ref_clk);
    device_reset_n <= 1'b1;
    rd(11'h005, 8'h00);
    rd(echo_port_pkg::STATUS_ADDR, 8'h01);
    finish_test();
  end
endmodule : tb
`default_nettype wire
